// ===== rtl/tsh_status_reg.sv
// One sticky write-one-to-clear throttle status register
`timescale 1ns/1ps
`default_nettype none
module tsh_status_reg
  import tsh_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Throttle measurement
  input  wire logic                 meas_valid,
  input  wire logic [TSH_PCT_W-1:0] meas_pct,
  input  wire logic                 over_limit,
  // Software clear
  input  wire logic                 clr_wr,
  input  wire logic [7:0]           clr_data,
  // Flags
  output logic      [7:0]           status
);
  logic [7:0] next_set;
  logic [7:0] next_clr;

  always_comb begin
    next_set = 8'h00;
    if (meas_valid) begin
      if (meas_pct > TSH_PCT_ZERO) begin
        next_set[TSH_BIT_ANY] = 1'b1;
      end
      if (meas_pct < TSH_PCT_12P5) begin
        next_set[TSH_BIT_LOWEST] = 1'b1;
      end else if (meas_pct < TSH_PCT_25) begin
        next_set[TSH_BIT_QUARTER] = 1'b1;
      end else if (meas_pct < TSH_PCT_50) begin
        next_set[TSH_BIT_HALF] = 1'b1;
      end else if (meas_pct < TSH_PCT_75) begin
        next_set[TSH_BIT_3QUART] = 1'b1;
      end else if (meas_pct < TSH_PCT_FULL) begin
        next_set[TSH_BIT_UPPER] = 1'b1;
      end else begin
        // Readings above full scale count as full throttling
        next_set[TSH_BIT_FULL] = 1'b1;
      end
    end
    // Limit compare lives outside; its pulse may come without a measurement
    next_set[TSH_BIT_OVER] = over_limit;
    next_clr = clr_wr ? clr_data : 8'h00;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status <= TSH_STATUS_RST;
    end else begin
      // Set is applied after clear so a coincident event is kept
      status <= (status & ~next_clr) | next_set;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tsh_throttle_status.sv
// Throttle status register bank for two processors
// Summary of operation
// - Any throttle flag sets when a measurement shows throttling above zero percent.
// - Lowest range flag sets for throttling from zero up to below 12.5 percent.
// - Middle flags set for 12.5-25, 25-50 and 50-75 percent ranges.
// - Upper range flag sets for throttling from 75 up to below 100 percent.
// - Full throttle flag, bit 6, sets when throttled the whole measurement.
// - Over-limit flag, bit 7, sets when throttling exceeds the user limit.
// - Only the over-limit flags drive the summary error flag.
// - Second processor has an identical register at offset 45h.
`timescale 1ns/1ps
`default_nettype none
module tsh_throttle_status
  import tsh_pkg::*;
(
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  // Processor one throttle measurement
  input  wire logic                         cpu_one_meas_valid,
  input  wire logic [tsh_pkg::TSH_PCT_W-1:0] cpu_one_throttle_in,
  input  wire logic                         cpu_one_over_limit,
  // Processor two throttle measurement
  input  wire logic                         cpu_two_meas_valid,
  input  wire logic [tsh_pkg::TSH_PCT_W-1:0] cpu_two_throttle_in,
  input  wire logic                         cpu_two_over_limit,
  // Register access port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_rd,
  output logic      [7:0]                   reg_rdata,
  // Summary
  output logic                              summary_error_flag,
  output logic                              cpu_one_over_limit_flag,
  output logic                              cpu_two_over_limit_flag
);
  logic [7:0] proc1_throttle_status;
  logic [7:0] proc2_throttle_status;
  logic       wr_one;
  logic       wr_two;

  assign wr_one = reg_wr && (reg_addr == TSH_OFS_CPU_ONE);
  assign wr_two = reg_wr && (reg_addr == TSH_OFS_CPU_TWO);

  tsh_status_reg u_cpu_one (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .meas_valid (cpu_one_meas_valid),
    .meas_pct   (cpu_one_throttle_in),
    .over_limit (cpu_one_over_limit),
    .clr_wr     (wr_one),
    .clr_data   (reg_wdata),
    .status     (proc1_throttle_status)
  );

  tsh_status_reg u_cpu_two (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .meas_valid (cpu_two_meas_valid),
    .meas_pct   (cpu_two_throttle_in),
    .over_limit (cpu_two_over_limit),
    .clr_wr     (wr_two),
    .clr_data   (reg_wdata),
    .status     (proc2_throttle_status)
  );

  // Read data is registered; reads have no side effect
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= TSH_READ_NONE;
    end else if (reg_rd) begin
      case (reg_addr)
        TSH_OFS_CPU_ONE: reg_rdata <= proc1_throttle_status;
        TSH_OFS_CPU_TWO: reg_rdata <= proc2_throttle_status;
        default:         reg_rdata <= TSH_READ_NONE;
      endcase
    end
  end

  // Range and full flags are deliberately left out of the summary
  assign cpu_one_over_limit_flag = proc1_throttle_status[TSH_BIT_OVER];
  assign cpu_two_over_limit_flag = proc2_throttle_status[TSH_BIT_OVER];
  assign summary_error_flag      = cpu_one_over_limit_flag | cpu_two_over_limit_flag;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_any_flag;
    cpu_one_meas_valid && (cpu_one_throttle_in != TSH_PCT_ZERO)
      |=> proc1_throttle_status[TSH_BIT_ANY];
  endproperty
  a_any_flag: assert property (p_any_flag) else $error("any-throttle flag not set");

  property p_lowest;
    cpu_one_meas_valid && (cpu_one_throttle_in < TSH_PCT_12P5)
      |=> proc1_throttle_status[TSH_BIT_LOWEST];
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest range flag not set");

  // A middle reading must not raise the lowest flag that was clear before
  property p_middle;
    cpu_one_meas_valid && (cpu_one_throttle_in >= TSH_PCT_12P5) && (cpu_one_throttle_in < TSH_PCT_75)
      |=> (proc1_throttle_status[TSH_BIT_QUARTER] || proc1_throttle_status[TSH_BIT_HALF]
           || proc1_throttle_status[TSH_BIT_3QUART])
          && (!proc1_throttle_status[TSH_BIT_LOWEST] || $past(proc1_throttle_status[TSH_BIT_LOWEST]));
  endproperty
  a_middle: assert property (p_middle) else $error("middle range flag wrong");

  property p_quarter;
    cpu_one_meas_valid && (cpu_one_throttle_in >= TSH_PCT_12P5) && (cpu_one_throttle_in < TSH_PCT_25)
      |=> proc1_throttle_status[TSH_BIT_QUARTER];
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter range flag not set");

  property p_three_quart;
    cpu_one_meas_valid && (cpu_one_throttle_in >= TSH_PCT_50) && (cpu_one_throttle_in < TSH_PCT_75)
      |=> proc1_throttle_status[TSH_BIT_3QUART];
  endproperty
  a_three_quart: assert property (p_three_quart) else $error("three-quarter range flag not set");

  property p_half_exact;
    cpu_one_meas_valid && (cpu_one_throttle_in >= TSH_PCT_25) && (cpu_one_throttle_in < TSH_PCT_50)
      |=> proc1_throttle_status[TSH_BIT_HALF];
  endproperty
  a_half_exact: assert property (p_half_exact) else $error("half range flag not set");

  property p_upper;
    cpu_one_meas_valid && (cpu_one_throttle_in >= TSH_PCT_75) && (cpu_one_throttle_in < TSH_PCT_FULL)
      |=> proc1_throttle_status[TSH_BIT_UPPER];
  endproperty
  a_upper: assert property (p_upper) else $error("upper range flag not set");

  property p_full;
    cpu_one_meas_valid && (cpu_one_throttle_in >= TSH_PCT_FULL)
      |=> proc1_throttle_status[TSH_BIT_FULL]
          && (!proc1_throttle_status[TSH_BIT_UPPER] || $past(proc1_throttle_status[TSH_BIT_UPPER]));
  endproperty
  a_full: assert property (p_full) else $error("full throttle flag wrong");

  property p_over;
    cpu_one_over_limit
      |=> proc1_throttle_status[TSH_BIT_OVER] && cpu_one_over_limit_flag && summary_error_flag;
  endproperty
  a_over: assert property (p_over) else $error("over-limit flag not set");

  property p_summary_cause;
    $rose(summary_error_flag) |-> $past(cpu_one_over_limit || cpu_two_over_limit);
  endproperty
  a_summary_cause: assert property (p_summary_cause) else $error("summary set without over-limit");

  property p_second_cpu;
    cpu_two_meas_valid && (cpu_two_throttle_in >= TSH_PCT_FULL)
      |=> proc2_throttle_status[TSH_BIT_FULL] && proc2_throttle_status[TSH_BIT_ANY];
  endproperty
  a_second_cpu: assert property (p_second_cpu) else $error("second processor register wrong");

  property p_hold;
    proc1_throttle_status[TSH_BIT_ANY] && !(wr_one && reg_wdata[TSH_BIT_ANY])
      |=> proc1_throttle_status[TSH_BIT_ANY];
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");

  property p_clear;
    wr_one && reg_wdata[TSH_BIT_OVER] && !cpu_one_over_limit |=> !proc1_throttle_status[TSH_BIT_OVER];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear flag");

  property p_set_wins;
    wr_one && reg_wdata[TSH_BIT_OVER] && cpu_one_over_limit |=> proc1_throttle_status[TSH_BIT_OVER];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under clear");

  // Second processor checked on its own so a slip in shared wiring shows up
  property p_two_any;
    cpu_two_meas_valid && (cpu_two_throttle_in != TSH_PCT_ZERO)
      |=> proc2_throttle_status[TSH_BIT_ANY];
  endproperty
  a_two_any: assert property (p_two_any) else $error("second any-throttle flag not set");

  property p_two_over;
    cpu_two_over_limit
      |=> proc2_throttle_status[TSH_BIT_OVER] && cpu_two_over_limit_flag && summary_error_flag;
  endproperty
  a_two_over: assert property (p_two_over) else $error("second over-limit flag not set");

  property p_range_quiet;
    !summary_error_flag && !cpu_one_over_limit && !cpu_two_over_limit |=> !summary_error_flag;
  endproperty
  a_range_quiet: assert property (p_range_quiet) else $error("summary set without limit event");

  property p_read_one;
    reg_rd && (reg_addr == TSH_OFS_CPU_ONE) |=> reg_rdata == $past(proc1_throttle_status);
  endproperty
  a_read_one: assert property (p_read_one) else $error("first register read wrong");

  property p_read_two;
    reg_rd && (reg_addr == TSH_OFS_CPU_TWO) |=> reg_rdata == $past(proc2_throttle_status);
  endproperty
  a_read_two: assert property (p_read_two) else $error("second register read wrong");

  // Unmapped offsets read as zero so software never sees stale flags there
  property p_read_none;
    reg_rd && (reg_addr != TSH_OFS_CPU_ONE) && (reg_addr != TSH_OFS_CPU_TWO)
      |=> reg_rdata == TSH_READ_NONE;
  endproperty
  a_read_none: assert property (p_read_none) else $error("unmapped read not zero");

  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

  property p_two_clear;
    wr_two && reg_wdata[TSH_BIT_OVER] && !cpu_two_over_limit |=> !proc2_throttle_status[TSH_BIT_OVER];
  endproperty
  a_two_clear: assert property (p_two_clear) else $error("second write one did not clear");

  property p_two_set_wins;
    wr_two && reg_wdata[TSH_BIT_OVER] && cpu_two_over_limit |=> proc2_throttle_status[TSH_BIT_OVER];
  endproperty
  a_two_set_wins: assert property (p_two_set_wins) else $error("second event lost under clear");

  c_full_seen:  cover property (cpu_one_meas_valid && cpu_one_throttle_in == TSH_PCT_FULL);
  c_summary_up: cover property ($rose(summary_error_flag));
  c_set_clear:  cover property (wr_two && reg_wdata[TSH_BIT_OVER] && cpu_two_over_limit);
  c_read_two:   cover property (reg_rd && reg_addr == TSH_OFS_CPU_TWO ##1 reg_rdata != TSH_READ_NONE);
  c_clear_two:  cover property (wr_two && reg_wdata[TSH_BIT_ANY] && proc2_throttle_status[TSH_BIT_ANY]);
endmodule
`default_nettype wire

// ===== shared/tsh_pkg.sv
// Constants for the processor throttle status register bank
package tsh_pkg;
  // Register offsets on the register access port
  localparam logic [7:0] TSH_OFS_CPU_ONE = 8'h44;
  localparam logic [7:0] TSH_OFS_CPU_TWO = 8'h45;
  localparam logic [7:0] TSH_STATUS_RST  = 8'h00;
  localparam logic [7:0] TSH_READ_NONE   = 8'h00;
  // Throttle measurement: 9 bits, 256 counts equal 100 percent
  localparam int         TSH_PCT_W       = 9;
  localparam logic [8:0] TSH_PCT_ZERO    = 9'h000;
  localparam logic [8:0] TSH_PCT_12P5    = 9'h020;
  localparam logic [8:0] TSH_PCT_25      = 9'h040;
  localparam logic [8:0] TSH_PCT_50      = 9'h080;
  localparam logic [8:0] TSH_PCT_75      = 9'h0C0;
  localparam logic [8:0] TSH_PCT_FULL    = 9'h100;
  // Flag positions inside each status register
  localparam int TSH_BIT_ANY     = 0;
  localparam int TSH_BIT_LOWEST  = 1;
  localparam int TSH_BIT_QUARTER = 2;
  localparam int TSH_BIT_HALF    = 3;
  localparam int TSH_BIT_3QUART  = 4;
  localparam int TSH_BIT_UPPER   = 5;
  localparam int TSH_BIT_FULL    = 6;
  localparam int TSH_BIT_OVER    = 7;
endpackage

// ===== tb/tb_throttle_histogram_status.sv
// Self-checking bench for the throttle status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_throttle_histogram_status;
  import tsh_pkg::*;
  logic       ref_clk, reset, rd_d;
  logic       cpu_one_meas_valid, cpu_one_over_limit, cpu_two_meas_valid, cpu_two_over_limit;
  logic [8:0] cpu_one_throttle_in, cpu_two_throttle_in, p;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, summary_error_flag, cpu_one_over_limit_flag, cpu_two_over_limit_flag;
  logic [1:0] req, ovl;
  logic [8:0] pct [2];
  logic [7:0] exp_reg [2];
  logic [7:0] q [$];
  logic [8:0] tbl [13] = '{9'h000, 9'h001, 9'h01F, 9'h020, 9'h03F, 9'h040, 9'h07F,
                           9'h080, 9'h0BF, 9'h0C0, 9'h0FF, 9'h100, 9'h1FF};
  int         fail_count, cmp_count, seed, c;
  tsh_throttle_status dut (.ref_clk, .reset, .cpu_one_meas_valid, .cpu_one_throttle_in,
    .cpu_one_over_limit, .cpu_two_meas_valid, .cpu_two_throttle_in, .cpu_two_over_limit,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .summary_error_flag,
    .cpu_one_over_limit_flag, .cpu_two_over_limit_flag);
  tsh_meas_model m1 (.ref_clk, .reset, .req(req[0]), .req_pct(pct[0]), .req_ovl(ovl[0]),
    .meas_valid(cpu_one_meas_valid), .meas_pct(cpu_one_throttle_in), .over_limit(cpu_one_over_limit));
  tsh_meas_model m2 (.ref_clk, .reset, .req(req[1]), .req_pct(pct[1]), .req_ovl(ovl[1]),
    .meas_valid(cpu_two_meas_valid), .meas_pct(cpu_two_throttle_in), .over_limit(cpu_two_over_limit));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Expected flags of one measurement: any (for a nonzero reading), exactly one range or full bit, and the over bit from o
  function automatic logic [7:0] hist(input logic [8:0] a, input logic o);
    logic [7:0] h;
    h = {o, 7'h00};
    h[0] = (a != TSH_PCT_ZERO);
    if (a < TSH_PCT_12P5) h[1] = 1'b1;
    else if (a < TSH_PCT_25) h[2] = 1'b1;
    else if (a < TSH_PCT_50) h[3] = 1'b1;
    else if (a < TSH_PCT_75) h[4] = 1'b1;
    else if (a < TSH_PCT_FULL) h[5] = 1'b1;
    else h[6] = 1'b1;
    return h;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    cmp_count++;
    if (got !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic meas(input int k, input logic [8:0] a, input logic o);
    @(posedge ref_clk);
    req[k] <= 1'b1;
    pct[k] <= a;
    ovl[k] <= o;
    exp_reg[k] |= hist(a, o);
    @(posedge ref_clk);
    req[k] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] m);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= m;
    if (a[7:1] == 7'h22) exp_reg[a[0]] &= ~m;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic sum();
    @(negedge ref_clk);
    chk({5'h00, summary_error_flag, cpu_one_over_limit_flag, cpu_two_over_limit_flag},
        {5'h00, exp_reg[0][7] | exp_reg[1][7], exp_reg[0][7], exp_reg[1][7]});
  endtask
  // Read results land one cycle after the request edge
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_d) chk(reg_rdata, q.pop_front());
  end
  task automatic finish_test();
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end
  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata, req, ovl} = {1'b1, 22'h000000};
    pct = '{9'h000, 9'h000};
    exp_reg = '{8'h00, 8'h00};
    seed = 32'hFF7BA95C;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(TSH_OFS_CPU_ONE, TSH_STATUS_RST);
    rd(TSH_OFS_CPU_TWO, TSH_STATUS_RST);
    rd(8'h46, TSH_READ_NONE);
    foreach (tbl[i]) begin
      meas(i % 2, tbl[i], 1'b0);
      rd(TSH_OFS_CPU_ONE + 8'(i % 2), exp_reg[i % 2]);
      sum();
      wr(TSH_OFS_CPU_ONE + 8'(i % 2), 8'hFF);
      rd(TSH_OFS_CPU_ONE + 8'(i % 2), 8'h00);
    end
    repeat (8) begin
      c = $random(seed) & 1;
      p = 9'($random(seed));
      meas(c, p, 1'($random(seed)));
      rd(TSH_OFS_CPU_ONE + 8'(c), exp_reg[c]);
      sum();
    end
    wr(TSH_OFS_CPU_TWO, 8'h00);
    wr(8'h46, 8'hFF);
    rd(TSH_OFS_CPU_TWO, exp_reg[1]);
    wr(TSH_OFS_CPU_ONE, 8'h7F);
    rd(TSH_OFS_CPU_ONE, exp_reg[0]);
    sum();
    // Event and clear on the same edge: the event must survive
    @(posedge ref_clk);
    {req[0], pct[0], ovl[0]} <= {1'b1, TSH_PCT_FULL, 1'b1};
    @(posedge ref_clk);
    {req[0], reg_wr, reg_addr, reg_wdata} <= {2'b01, TSH_OFS_CPU_ONE, 8'hFF};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    exp_reg[0] = hist(TSH_PCT_FULL, 1'b1);
    rd(TSH_OFS_CPU_ONE, exp_reg[0]);
    sum();
    repeat (2) @(posedge ref_clk);
    finish_test();
  end
endmodule
`default_nettype wire

// ===== tb/tsh_meas_model.sv
// Behavioural throttle measurement source for one processor
`timescale 1ns/1ps
`default_nettype none
module tsh_meas_model
  import tsh_pkg::*;
(
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  // Request from the bench
  input  wire logic                          req,
  input  wire logic [tsh_pkg::TSH_PCT_W-1:0] req_pct,
  input  wire logic                          req_ovl,
  // Measurement towards the block
  output logic                               meas_valid,
  output logic      [tsh_pkg::TSH_PCT_W-1:0] meas_pct,
  output logic                               over_limit
);
  // Amount turns over between pulses so a stale value is never trusted
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meas_valid <= 1'b0;
      meas_pct   <= 9'h000;
      over_limit <= 1'b0;
    end else begin
      meas_valid <= req;
      over_limit <= req & req_ovl;
      meas_pct   <= req ? req_pct : ~meas_pct;
    end
  end
endmodule
`default_nettype wire
